// ===== frlr_top.sv
// Behaviour
// RULE1 - Mass flow now is published as a float in the selected mass unit.
// RULE2 - The mass flow temperature correction factor is published.
// RULE3 - A display-filtered copy of mass flow is published.
// RULE4 - A frequency-output-filtered copy of mass flow is published.
// RULE5 - A bus-loop-filtered copy of mass flow is published.
// RULE6 - A loop copy without the low-flow cut-off is published.
// RULE7 - The computed mass flow correction factor is published.
// RULE8 - Volumetric flow is mass flow divided by density.
// RULE9 - Density comes from internal, user or analog source.
// RULE10 - Volumetric flow is zero whenever no valid density is present.
// RULE11 - Warnings bit 2 sets when volume flow exceeds the upper limit.
// RULE12 - Warnings bit 2 sets when volume flow is below the lower limit.
// RULE13 - The warning needs a programmable run of violating cycles.
// RULE14 - One integrator cycle is four sensor oscillation periods.
// RULE15 - Three correction volumes in cm3 act only with special function 1.
// RULE16 - Warning limits are in the selected volume flow unit.
// RULE17 - The violation run count clears on any in-range cycle.
`timescale 1ns/1ps
`default_nettype none
module frlr_top
  import frlr_pkg::*;
(
  input  wire logic        clk_i,          // 40 MHz clock
  input  wire logic        rst_i,          // Synchronous reset
  input  wire logic        osc_i,          // Sensor oscillation pin
  input  wire logic [31:0] mass_flow_i,    // Mass flow, selected unit
  input  wire logic [31:0] temp_factor_i,  // Temperature correction
  input  wire logic [31:0] display_i,      // Display-filtered flow
  input  wire logic [31:0] pulse_i,        // Freq-output-filtered flow
  input  wire logic [31:0] loop_i,         // Loop-filtered flow
  input  wire logic [31:0] uncut_i,        // Loop flow, no cut-off
  input  wire logic [31:0] corr_factor_i,  // Flow correction factor
  input  wire logic [1:0]  dens_src_i,     // Density source select
  input  wire logic [31:0] dens_int_i,     // Measured density
  input  wire logic        dens_int_ok_i,  // Measured density valid
  input  wire logic [31:0] dens_user_i,    // User-parameter density
  input  wire logic [31:0] dens_ana_i,     // Analog-input density
  input  wire logic        dens_ana_ok_i,  // Analog density valid
  input  wire logic        special_fn1_i,  // Special function 1 on
  input  wire logic        wr_i,           // Register write strobe
  input  wire logic        rd_i,           // Register read strobe
  input  wire logic [15:0] addr_i,         // Register address
  input  wire logic [31:0] wdata_i,        // Write data
  output logic      [31:0] rdata_o,        // Read data
  output logic             ack_o,          // Access done pulse
  output logic             err_o,          // Access refused pulse
  output logic      [31:0] vol_flow_o,     // Volumetric flow, float
  output logic             vol_warn_o,     // Volumetric warning
  output logic             cycle_o,        // Integrator cycle pulse
  output logic      [31:0] corr_warm_o,    // Effective volume A1
  output logic      [31:0] corr_cold_o,    // Effective volume A2
  output logic      [31:0] corr_third_o    // Effective volume B
);
  frlr_div_if div ();

  logic        osc_s1_r;
  logic        osc_s2_r;
  logic        osc_s3_r;
  logic        osc_lvl_r;
  logic [1:0]  osc_cnt_r;
  logic        osc_rise;
  logic [31:0] mass_now_r;
  logic [31:0] temp_factor_r;
  logic [31:0] display_r;
  logic [31:0] pulse_r;
  logic [31:0] loop_r;
  logic [31:0] uncut_r;
  logic [31:0] corr_factor_r;
  logic [31:0] high_limit_r;
  logic [31:0] low_limit_r;
  logic [31:0] persist_r;
  logic [31:0] corr_warm_r;
  logic [31:0] corr_cold_r;
  logic [31:0] corr_third_r;
  logic        start_r;
  logic [31:0] dividend_r;
  logic [31:0] divisor_r;
  logic        dens_ok_r;
  logic        mon_tick_r;
  logic        warn;
  logic [31:0] dens_sel;
  logic        dens_sel_ok;

  ////////////////////////////////////////////////////////////////////////
  // Oscillation pin: three stages, level moves once stages 2 and 3 agree
  // Level resets low like the idle pin, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      osc_lvl_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      if (osc_s2_r == osc_s3_r) begin
        osc_lvl_r <= osc_s3_r;
      end
    end
  end

  assign osc_rise = (osc_s2_r == osc_s3_r) && osc_s3_r && !osc_lvl_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_r <= 2'h0;
      cycle_o   <= 1'b0;
    end else begin
      cycle_o <= 1'b0;
      if (osc_rise) begin
        osc_cnt_r <= osc_cnt_r + 2'h1;
        if (osc_cnt_r == CYCLE_DIV_LAST) begin
          cycle_o <= 1'b1;                                    // [RULE14]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Results are snapped once per cycle so a reader sees one coherent set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mass_now_r    <= RST_VALUE;
      temp_factor_r <= RST_VALUE;
      display_r     <= RST_VALUE;
      pulse_r       <= RST_VALUE;
      loop_r        <= RST_VALUE;
      uncut_r       <= RST_VALUE;
      corr_factor_r <= RST_VALUE;
    end else if (cycle_o) begin
      mass_now_r    <= mass_flow_i;                           // [RULE1]
      temp_factor_r <= temp_factor_i;                         // [RULE2]
      display_r     <= display_i;                             // [RULE3]
      pulse_r       <= pulse_i;                               // [RULE4]
      loop_r        <= loop_i;                                // [RULE5]
      uncut_r       <= uncut_i;                               // [RULE6]
      corr_factor_r <= corr_factor_i;                         // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Density source and volumetric flow
  always_comb begin
    dens_sel    = dens_user_i;
    dens_sel_ok = 1'b0;
    unique case (dens_src_i)                                  // [RULE9]
      DENS_SRC_INTERNAL: begin
        dens_sel    = dens_int_i;
        dens_sel_ok = dens_int_ok_i;
      end
      DENS_SRC_USER: begin
        dens_sel    = dens_user_i;
        dens_sel_ok = 1'b1;
      end
      DENS_SRC_ANALOG: begin
        dens_sel    = dens_ana_i;
        dens_sel_ok = dens_ana_ok_i;
      end
      default: begin
        dens_sel    = dens_user_i;
        dens_sel_ok = 1'b0;
      end
    endcase
  end

  assign div.start    = start_r;
  assign div.dividend = dividend_r;
  assign div.divisor  = divisor_r;

  // The divide takes under 30 clocks, far inside one sensor cycle
  // A cycle landing while the divide is busy would be lost, not queued
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r    <= 1'b0;
      dividend_r <= RST_VALUE;
      divisor_r  <= RST_VALUE;
      dens_ok_r  <= 1'b0;
      vol_flow_o <= RST_VALUE;
      mon_tick_r <= 1'b0;
    end else begin
      start_r    <= cycle_o;
      mon_tick_r <= div.done;
      if (cycle_o) begin
        dividend_r <= mass_flow_i;                            // [RULE8]
        divisor_r  <= dens_sel;
        dens_ok_r  <= dens_sel_ok && frlr_fp_usable(dens_sel);
      end
      if (div.done) begin
        vol_flow_o <= dens_ok_r ? div.quotient : RST_VALUE;   // [RULE10]
      end
    end
  end

  frlr_fdiv u_fdiv (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .div   (div)
  );

  // Limits and flow share the volume unit chosen outside  [RULE16]
  frlr_limit u_limit (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (mon_tick_r),
    .vol_i  (vol_flow_o),
    .high_i (high_limit_r),
    .low_i  (low_limit_r),
    .thr_i  (persist_r),
    .warn_o (warn)
  );

  ////////////////////////////////////////////////////////////////////////
  // Holding registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_limit_r <= RST_HIGH_LIMIT;                         // [RULE11]
      low_limit_r  <= RST_LOW_LIMIT;                          // [RULE12]
      persist_r    <= RST_PERSIST_COUNT;                      // [RULE13]
      corr_warm_r  <= RST_CORR_VOLUME;
      corr_cold_r  <= RST_CORR_VOLUME;
      corr_third_r <= RST_CORR_VOLUME;
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_HIGH_LIMIT:    high_limit_r <= wdata_i;
        ADDR_LOW_LIMIT:     low_limit_r  <= wdata_i;
        ADDR_PERSIST_COUNT: persist_r    <= wdata_i;
        ADDR_CORR_WARM:     corr_warm_r  <= wdata_i;
        ADDR_CORR_COLD:     corr_cold_r  <= wdata_i;
        ADDR_CORR_THIRD:    corr_third_r <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Volumes act only under function 1; read-back is not gated  [RULE15]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      corr_warm_o  <= RST_CORR_VOLUME;
      corr_cold_o  <= RST_CORR_VOLUME;
      corr_third_o <= RST_CORR_VOLUME;
      vol_warn_o   <= 1'b0;
    end else begin
      corr_warm_o  <= special_fn1_i ? corr_warm_r  : RST_CORR_VOLUME;
      corr_cold_o  <= special_fn1_i ? corr_cold_r  : RST_CORR_VOLUME;
      corr_third_o <= special_fn1_i ? corr_third_r : RST_CORR_VOLUME;
      vol_warn_o   <= warn;                                   // [RULE11]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access answer; writes to read-only or unknown addresses are refused
  // A write and a read in one cycle: the write wins, the read is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= RST_VALUE;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      if (wr_i) begin
        unique case (addr_i)
          ADDR_HIGH_LIMIT, ADDR_LOW_LIMIT, ADDR_PERSIST_COUNT,
          ADDR_CORR_WARM, ADDR_CORR_COLD, ADDR_CORR_THIRD: ack_o <= 1'b1;
          default: err_o <= 1'b1;
        endcase
      end else if (rd_i) begin
        ack_o <= 1'b1;
        unique case (addr_i)
          ADDR_WARNINGS: begin
            rdata_o               <= RST_VALUE;
            rdata_o[WARN_VOL_BIT] <= warn;                    // [RULE11]
          end
          ADDR_MASS_NOW:      rdata_o <= mass_now_r;          // [RULE1]
          ADDR_TEMP_FACTOR:   rdata_o <= temp_factor_r;       // [RULE2]
          ADDR_DISPLAY_COPY:  rdata_o <= display_r;           // [RULE3]
          ADDR_PULSE_COPY:    rdata_o <= pulse_r;             // [RULE4]
          ADDR_LOOP_COPY:     rdata_o <= loop_r;              // [RULE5]
          ADDR_UNCUT:         rdata_o <= uncut_r;             // [RULE6]
          ADDR_CORR_FACTOR:   rdata_o <= corr_factor_r;       // [RULE7]
          ADDR_VOL_FLOW:      rdata_o <= vol_flow_o;
          ADDR_HIGH_LIMIT:    rdata_o <= high_limit_r;
          ADDR_LOW_LIMIT:     rdata_o <= low_limit_r;
          ADDR_PERSIST_COUNT: rdata_o <= persist_r;
          ADDR_CORR_WARM:     rdata_o <= corr_warm_r;
          ADDR_CORR_COLD:     rdata_o <= corr_cold_r;
          ADDR_CORR_THIRD:    rdata_o <= corr_third_r;
          default: begin
            rdata_o <= RST_VALUE;
            ack_o   <= 1'b0;
            err_o   <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== frlr_pkg.sv
`default_nettype none
package frlr_pkg;
  // Register addresses, one 32-bit value per address
  localparam logic [15:0] ADDR_WARNINGS      = 16'h401E;
  localparam logic [15:0] ADDR_MASS_NOW      = 16'h4900;
  localparam logic [15:0] ADDR_TEMP_FACTOR   = 16'h4902;
  localparam logic [15:0] ADDR_DISPLAY_COPY  = 16'h4904;
  localparam logic [15:0] ADDR_PULSE_COPY    = 16'h4906;
  localparam logic [15:0] ADDR_LOOP_COPY     = 16'h4908;
  localparam logic [15:0] ADDR_UNCUT         = 16'h490A;
  localparam logic [15:0] ADDR_CORR_FACTOR   = 16'h490C;
  localparam logic [15:0] ADDR_VOL_FLOW      = 16'h4A00;
  localparam logic [15:0] ADDR_HIGH_LIMIT    = 16'h6A06;
  localparam logic [15:0] ADDR_LOW_LIMIT     = 16'h6A08;
  localparam logic [15:0] ADDR_PERSIST_COUNT = 16'h6A0A;
  localparam logic [15:0] ADDR_CORR_WARM     = 16'h6A0C;
  localparam logic [15:0] ADDR_CORR_COLD     = 16'h6A0E;
  localparam logic [15:0] ADDR_CORR_THIRD    = 16'h6A10;

  // Warnings register field
  localparam int          WARN_VOL_BIT       = 2;

  // Reset values; the nominal 7E38 exceeds single range, so the
  // largest finite magnitude stands in for it
  localparam logic [31:0] RST_HIGH_LIMIT     = 32'h7F7FFFFF;
  localparam logic [31:0] RST_LOW_LIMIT      = 32'hFF7FFFFF;
  localparam logic [31:0] RST_PERSIST_COUNT  = 32'h00000003;
  localparam logic [31:0] RST_CORR_VOLUME    = 32'h00000000;
  localparam logic [31:0] RST_VALUE          = 32'h00000000;

  // Last count of the four sensor oscillation periods per integrator cycle
  localparam logic [1:0]  CYCLE_DIV_LAST     = 2'h3;

  // Density source selection
  localparam logic [1:0]  DENS_SRC_INTERNAL  = 2'h0;
  localparam logic [1:0]  DENS_SRC_USER      = 2'h1;
  localparam logic [1:0]  DENS_SRC_ANALOG    = 2'h2;

  // Float layout
  localparam int          FP_EXP_LSB         = 23;
  localparam logic [7:0]  FP_EXP_MAX         = 8'hFF;
  localparam logic [9:0]  FP_BIAS            = 10'h07F;
  localparam logic [4:0]  DIV_STEPS          = 5'h19;

  // Maps a float onto an unsigned key that sorts like the value
  function automatic logic [31:0] frlr_fp_key(input logic [31:0] f);
    frlr_fp_key = f[31] ? ~f : {1'b1, f[30:0]};
  endfunction

  // A usable density is finite, positive and normal
  function automatic logic frlr_fp_usable(input logic [31:0] f);
    frlr_fp_usable = !f[31] && (f[30:23] != 8'h00) &&
                     (f[30:23] != FP_EXP_MAX);
  endfunction
endpackage
`default_nettype wire

// ===== frlr_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frlr_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        done;
  logic [31:0] quotient;
  modport req (output start, output dividend, output divisor,
               input done, input quotient);
  modport rsp (input start, input dividend, input divisor,
               output done, output quotient);
endinterface
`default_nettype wire

// ===== frlr_fdiv.sv
`timescale 1ns/1ps
`default_nettype none
module frlr_fdiv
  import frlr_pkg::*;
(
  input  wire logic clk_i,       // System clock
  input  wire logic rst_i,       // Synchronous reset
  frlr_div_if.rsp   div          // Divide request and answer
);
  typedef enum logic [1:0] {FRLR_IDLE, FRLR_RUN, FRLR_PACK} frlr_div_st_t;

  frlr_div_st_t st_r;
  logic [24:0]  rem_r;
  logic [23:0]  den_r;
  logic [24:0]  quo_r;
  logic [9:0]   exp_r;
  logic         sgn_r;
  logic         zero_r;
  logic [4:0]   step_r;
  logic [31:0]  quotient_r;
  logic         done_r;
  logic [24:0]  diff;
  logic [9:0]   exp_adj;

  assign diff         = rem_r - {1'b0, den_r};
  assign exp_adj      = quo_r[24] ? exp_r : exp_r - 10'h001;
  assign div.done     = done_r;
  assign div.quotient = quotient_r;

  ////////////////////////////////////////////////////////////////////////
  // Restoring mantissa divide, one quotient bit per clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= FRLR_IDLE;
      rem_r  <= 25'h0000000;
      den_r  <= 24'h000000;
      quo_r  <= 25'h0000000;
      exp_r  <= 10'h000;
      sgn_r  <= 1'b0;
      zero_r <= 1'b0;
      step_r <= 5'h00;
    end else begin
      unique case (st_r)
        FRLR_IDLE: begin
          if (div.start) begin
            rem_r  <= {2'h1, div.dividend[22:0]};
            den_r  <= {1'b1, div.divisor[22:0]};
            quo_r  <= 25'h0000000;
            exp_r  <= {2'h0, div.dividend[30:23]} -
                      {2'h0, div.divisor[30:23]} + FP_BIAS;
            sgn_r  <= div.dividend[31] ^ div.divisor[31];
            // Denormal mass flow is read as zero flow
            zero_r <= (div.dividend[30:23] == 8'h00);
            step_r <= 5'h00;
            st_r   <= FRLR_RUN;
          end
        end
        FRLR_RUN: begin
          if (!diff[24]) begin
            rem_r <= {diff[23:0], 1'b0};
            quo_r <= {quo_r[23:0], 1'b1};
          end else begin
            rem_r <= {rem_r[23:0], 1'b0};
            quo_r <= {quo_r[23:0], 1'b0};
          end
          step_r <= step_r + 5'h01;
          if (step_r == DIV_STEPS - 5'h01) begin
            st_r <= FRLR_PACK;
          end
        end
        FRLR_PACK: begin
          st_r <= FRLR_IDLE;
        end
        default: begin
          st_r <= FRLR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Normalise and pack; truncation keeps the path short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quotient_r <= RST_VALUE;
      done_r     <= 1'b0;
    end else begin
      done_r <= (st_r == FRLR_PACK);
      if (st_r == FRLR_PACK) begin
        if (zero_r || exp_adj[9] || exp_adj == 10'h000) begin
          quotient_r <= RST_VALUE;
        end else if (exp_adj[8:0] >= {1'b0, FP_EXP_MAX}) begin
          quotient_r <= {sgn_r, 31'h7F7FFFFF};
        end else if (quo_r[24]) begin
          quotient_r <= {sgn_r, exp_adj[7:0], quo_r[23:1]};
        end else begin
          quotient_r <= {sgn_r, exp_adj[7:0], quo_r[22:0]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== frlr_limit.sv
`timescale 1ns/1ps
`default_nettype none
module frlr_limit
  import frlr_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Synchronous reset
  input  wire logic        tick_i,    // New volumetric value present
  input  wire logic [31:0] vol_i,     // Volumetric flow, float
  input  wire logic [31:0] high_i,    // Upper warning limit, float
  input  wire logic [31:0] low_i,     // Lower warning limit, float
  input  wire logic [31:0] thr_i,     // Consecutive cycles needed
  output logic             warn_o     // Volumetric flow warning
);
  logic [31:0] run_r;
  logic [31:0] need;
  logic        over;
  logic        under;

  // A threshold of zero behaves as one
  assign need  = (thr_i == 32'h00000000) ? 32'h00000001 : thr_i;
  assign over  = frlr_fp_key(vol_i) > frlr_fp_key(high_i);    // [RULE11]
  assign under = frlr_fp_key(vol_i) < frlr_fp_key(low_i);     // [RULE12]

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r  <= 32'h00000000;
      warn_o <= 1'b0;
    end else if (tick_i) begin
      if (over || under) begin
        if (run_r != 32'hFFFFFFFF) begin
          run_r <= run_r + 32'h00000001;
        end
        // Counts the present cycle as well
        if (run_r + 32'h00000001 >= need) begin
          warn_o <= 1'b1;                                     // [RULE13]
        end
      end else begin
        run_r  <= 32'h00000000;                               // [RULE17]
        warn_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== frlr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module frlr_monitor
  import frlr_pkg::*;
(
  input wire logic        clk_i,         // Clock
  input wire logic        rst_i,         // Reset
  input wire logic        wr_i,          // Write strobe
  input wire logic        rd_i,          // Read strobe
  input wire logic [15:0] addr_i,        // Address
  input wire logic [1:0]  dens_src_i,    // Density source
  input wire logic [31:0] mass_flow_i,   // Mass flow
  input wire logic        special_fn1_i, // Special function 1
  input wire logic [31:0] rdata_o,       // Read data
  input wire logic        ack_o,         // Done
  input wire logic        err_o,         // Refused
  input wire logic [31:0] vol_flow_o,    // Volumetric flow
  input wire logic        vol_warn_o,    // Warning
  input wire logic        cycle_o,       // Integrator cycle
  input wire logic [31:0] corr_warm_o    // Volume A1
);
  logic [7:0]  since_r;
  logic [7:0]  nodens_r;
  logic [31:0] mass_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || cycle_o) since_r <= 8'h00;
    else if (since_r != 8'hFF) since_r <= since_r + 8'h01;
  end
  // Counts how long no density source has been selected
  always_ff @(posedge clk_i) begin
    if (rst_i || dens_src_i != 2'h3) nodens_r <= 8'h00;
    else if (nodens_r != 8'hFF) nodens_r <= nodens_r + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) mass_r <= 32'h00000000;
    else if (cycle_o) mass_r <= mass_flow_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd(a);
    rd_i && !wr_i && addr_i == a;
  endsequence

  a_access_answer: assert property (
    (rd_i || wr_i) |=> (ack_o != err_o)) else $error("access unanswered");
  a_ro_refused: assert property (
    wr_i && addr_i == ADDR_MASS_NOW |=> err_o && !ack_o)
    else $error("read-only write not refused");
  a_mass_read: assert property (
    s_rd(ADDR_MASS_NOW) ##0 since_r >= 8'h02 |=> rdata_o == mass_r)
    else $error("mass flow read wrong");
  a_warn_read: assert property (
    s_rd(ADDR_WARNINGS) |=> rdata_o == {29'h0, vol_warn_o, 2'h0})
    else $error("warnings read wrong");
  a_no_density: assert property (
    {1'b0, nodens_r} > {1'b0, since_r} + 9'h002 && since_r >= 8'h28 |->
    vol_flow_o == 32'h0)
    else $error("volume flow without density");
  a_warn_timing: assert property (
    $changed(vol_warn_o) |-> since_r >= 8'h14 && since_r <= 8'h2D)
    else $error("warning changed off cycle");
  a_cycle_spacing: assert property (
    cycle_o |=> !cycle_o [*8]) else $error("cycles too close");
  a_corr_gated: assert property (
    !special_fn1_i |=> corr_warm_o == 32'h0)
    else $error("volume active without function");
endmodule
`default_nettype wire

// ===== frlr_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module frlr_sensor_model #(
  parameter int HALF = 10
) (
  input  wire logic clk_i,   // Clock
  input  wire logic start_i, // Request one integrator cycle
  output logic      osc_o    // Oscillation pin
);
  int cnt = 0;

  // Whole periods only, then the pin rests low so no stray edge counts
  always_ff @(posedge clk_i) begin
    if (cnt != 0) cnt <= cnt - 1;
    else if (start_i) cnt <= 8 * HALF;
  end
  assign osc_o = (cnt % (2 * HALF)) >= HALF;
endmodule
`default_nettype wire

// ===== flow_rate_result_and_limit_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flow_rate_result_and_limit_regs_tb;
  import frlr_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start = 1'b0;
  logic        sfn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        di_ok = 1'b1;
  logic        da_ok = 1'b1;
  logic        osc, ack, err, warn, cyc;
  logic [1:0]  dsrc = 2'h1;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, vol, cw, cc, ct, got;
  logic [31:0] di = 32'h3F800000;
  logic [31:0] du = 32'h40000000;
  logic [31:0] da = 32'h40800000;
  logic [31:0] res [7] = '{default: 32'h0};
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;

  initial forever #12.5 clk_i = ~clk_i;

  // Every sensor burst is four periods, so one integrator cycle each
  always @(posedge clk_i) if (cyc === 1'b1) cycles++;

  frlr_sensor_model u_sensor (.clk_i(clk_i), .start_i(start), .osc_o(osc));
  frlr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .osc_i(osc),
    .mass_flow_i(res[0]), .temp_factor_i(res[1]), .display_i(res[2]),
    .pulse_i(res[3]), .loop_i(res[4]), .uncut_i(res[5]),
    .corr_factor_i(res[6]), .dens_src_i(dsrc), .dens_int_i(di),
    .dens_int_ok_i(di_ok), .dens_user_i(du), .dens_ana_i(da),
    .dens_ana_ok_i(da_ok), .special_fn1_i(sfn), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ack_o(ack),
    .err_o(err), .vol_flow_o(vol), .vol_warn_o(warn), .cycle_o(cyc),
    .corr_warm_o(cw), .corr_cold_o(cc), .corr_third_o(ct));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic e);
    @(posedge clk_i) #2;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk_i) #2;
    wr = 1'b0;
    rd = 1'b0;
    check({31'h0, err}, {31'h0, e});
    check({31'h0, ack}, {31'h0, !e});
    got = rdata;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 1'b0);
    check(got, e);
  endtask

  // Waits out the divide and the two-stage warning path
  task automatic run_cycle();
    int n;
    n = 0;
    @(posedge clk_i) #2 start = 1'b1;
    @(posedge clk_i) #2 start = 1'b0;
    while (cyc !== 1'b1 && n < 300) begin
      @(posedge clk_i) #2;
      n++;
    end
    if (n >= 300) check(32'h1, 32'h0);
    repeat (45) @(posedge clk_i);
    #2;
  endtask

  task automatic vcase(input logic [1:0] s, input logic ok,
                       input logic [31:0] e);
    dsrc = s;
    di_ok = ok;
    da_ok = ok;
    run_cycle();
    check(vol, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    #2 rst_i = 1'b0;
    rchk(ADDR_HIGH_LIMIT, RST_HIGH_LIMIT);
    rchk(ADDR_LOW_LIMIT, RST_LOW_LIMIT);
    rchk(ADDR_PERSIST_COUNT, RST_PERSIST_COUNT);
    rchk(ADDR_CORR_WARM, RST_CORR_VOLUME);
    acc(1'b1, ADDR_MASS_NOW, 32'h1, 1'b1);
    acc(1'b0, 16'h1234, 32'h0, 1'b1);
    check(got, 32'h0);
    for (int i = 0; i < 7; i++) res[i] = 32'h40800000 | 32'(i);
    run_cycle();
    for (int i = 0; i < 7; i++)
      rchk(ADDR_MASS_NOW + 16'(2 * i), res[i]);
    rchk(ADDR_VOL_FLOW, 32'h40000000);
    vcase(DENS_SRC_INTERNAL, 1'b1, 32'h40800000);
    vcase(DENS_SRC_ANALOG, 1'b1, 32'h3F800000);
    vcase(DENS_SRC_ANALOG, 1'b0, 32'h0);
    vcase(DENS_SRC_INTERNAL, 1'b0, 32'h0);
    vcase(2'h3, 1'b1, 32'h0);
    du = 32'hC0000000;
    vcase(DENS_SRC_USER, 1'b1, 32'h0);
    // Flow 2.0 against an upper limit of 1.0
    du = 32'h40000000;
    acc(1'b1, ADDR_HIGH_LIMIT, 32'h3F800000, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run_cycle();
      check({31'h0, warn}, {31'h0, i == 2});
    end
    rchk(ADDR_WARNINGS, 32'h4);
    res[0] = 32'h3F800000;
    vcase(DENS_SRC_USER, 1'b1, 32'h3F000000);
    check({31'h0, warn}, 32'h0);
    // Lower limit 0.75, run of two; a flow equal to it is in range
    acc(1'b1, ADDR_LOW_LIMIT, 32'h3F400000, 1'b0);
    acc(1'b1, ADDR_PERSIST_COUNT, 32'h2, 1'b0);
    run_cycle();
    res[0] = 32'h3FC00000;
    run_cycle();
    res[0] = 32'h3F800000;
    run_cycle();
    check({31'h0, warn}, 32'h0);
    run_cycle();
    check({31'h0, warn}, 32'h1);
    acc(1'b1, ADDR_CORR_WARM, 32'h3F000001, 1'b0);
    acc(1'b1, ADDR_CORR_COLD, 32'h3F000002, 1'b0);
    acc(1'b1, ADDR_CORR_THIRD, 32'h3F000003, 1'b0);
    check(cw | cc | ct, 32'h0);
    sfn = 1'b1;
    repeat (2) @(posedge clk_i);
    #2;
    check(cw, 32'h3F000001);
    check(cc, 32'h3F000002);
    check(ct, 32'h3F000003);
    check(32'(cycles), 32'h0000000F);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
endmodule

bind frlr_top frlr_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .dens_src_i(dens_src_i),
  .mass_flow_i(mass_flow_i), .special_fn1_i(special_fn1_i),
  .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o),
  .vol_flow_o(vol_flow_o), .vol_warn_o(vol_warn_o), .cycle_o(cycle_o),
  .corr_warm_o(corr_warm_o));
`default_nettype wire
